/* verilog/bsp_pkg.sv */
package bsp_pkg;
    // ------------------------------------------------------------
    // header layout
    // ------------------------------------------------------------
    localparam int HDR_BYTES      = 10;
    localparam int ADDR_LAST_BYTE = 3;
    localparam int CNT_LAST_BYTE  = 7;
    localparam int FLAG_LAST_BYTE = 9;
    localparam logic [3:0] HDR_IDX_W0 = 4'h0;
    // ------------------------------------------------------------
    // default flag bit positions
    // ------------------------------------------------------------
    localparam int FLAG_ZERO_POS  = 0;
    localparam int FLAG_IGN_POS   = 4;
    localparam int FLAG_INIT_POS  = 3;
    localparam int FLAG_PTYPE_POS = 1;
    localparam int FLAG_LAST_POS  = 15;
    // ------------------------------------------------------------
    // addresses
    // ------------------------------------------------------------
    localparam logic [31:0] STACK_TOP     = 32'hFFB00FFC;
    localparam logic [31:0] JUMP_VARIANT0 = 32'hFFA00000;
    localparam logic [31:0] JUMP_VARIANT1 = 32'hFFA08000;
    localparam logic [31:0] TWB_BUF_LO    = 32'hFF903F00;
    localparam logic [31:0] TWB_BUF_HI    = 32'hFF903FFF;
    localparam logic [31:0] ZERO_WORD     = 32'h00000000;
    // ------------------------------------------------------------
    // buffering
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_WIDTH = 8;

    typedef enum logic [2:0] {
        ST_HDR,
        ST_BODY,
        ST_SKIP,
        ST_ZERO,
        ST_CALL,
        ST_WAIT_RET,
        ST_DONE
    } bsp_state_type;
endpackage

/* verilog/bsp_fifo.sv */
`timescale 1ns/1ps
module bsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      fill;
    logic             push;
    logic             pop;

    assign in_ready_o  = (fill != DEPTH[AW:0]);
    assign out_valid_o = (fill != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_bounds: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        fill <= DEPTH[AW:0]) else $error("fifo fill out of range");
endmodule

/* verilog/bsp_parser.sv */
`timescale 1ns/1ps
// Summary of operation
// RL1: header is address, count, flags, ten bytes
// RL2: zero-fill writes count zeros, no body
// RL3: producer uses zero-fill for large zero buffers
// RL4: ignore flag skips block, no writes
// RL5: init block loaded then called, wait return
// RL6: init code ends with a return
// RL7: init blocks come first in stream
// RL8: init blocks run before application loading
// RL9: stack pointer set to scratchpad top first
// RL10: init code saves and restores registers
// RL11: blocks processed until last block
// RL12: after last, jump to level-one start
// RL13: processor-type flag chooses jump target
// RL14: two-wire mode reserves buffer range
// RL15: producer puts reserved-range data in last
// RL16: holdoff strobe high during init, zero-fill
// RL17: flag positions parameters, fields little-endian
module bsp_parser #(
    parameter int ZERO_POS  = bsp_pkg::FLAG_ZERO_POS,
    parameter int IGN_POS   = bsp_pkg::FLAG_IGN_POS,
    parameter int INIT_POS  = bsp_pkg::FLAG_INIT_POS,
    parameter int PTYPE_POS = bsp_pkg::FLAG_PTYPE_POS,
    parameter int LAST_POS  = bsp_pkg::FLAG_LAST_POS,
    parameter int DEPTH     = bsp_pkg::FIFO_DEPTH
) (
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  wire logic [7:0]  src_data_i,
    input  wire logic        src_valid_i,
    output logic             src_ready_o,
    input  wire logic        two_wire_boot_mode_i,
    output logic [31:0]      mem_addr_o,
    output logic [7:0]       mem_data_o,
    output logic             mem_we_o,
    input  wire logic        mem_ready_i,
    output logic             call_o,
    output logic [31:0]      call_addr_o,
    output logic [31:0]      stack_pointer_o,
    input  wire logic        ret_i,
    output logic             boot_done_o,
    output logic [31:0]      jump_addr_o,
    output logic             lowest_priority_interrupt_level_o,
    output logic             host_holdoff_strobe_o,
    output logic             range_err_o
);
    // ------------------------------------------------------------
    // input buffer
    // ------------------------------------------------------------
    logic [7:0] byte_d;
    logic       byte_v;
    logic       byte_take;

    bsp_fifo #(
        .WIDTH (bsp_pkg::FIFO_WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .arst_n_i    (arst_n_i),
        .in_data_i   (src_data_i),
        .in_valid_i  (src_valid_i),
        .in_ready_o  (src_ready_o),
        .out_data_o  (byte_d),
        .out_valid_o (byte_v),
        .out_ready_i (byte_take)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bsp_pkg::bsp_state_type state;
    logic [3:0]  hdr_idx;
    logic [31:0] blk_addr;
    logic [31:0] blk_cnt;
    logic [15:0] blk_flags;
    logic [31:0] wr_addr;
    logic [31:0] remain;
    logic        is_init;
    logic        wr_pend;
    logic        hdr_end;

    function automatic logic in_twb_buf(input logic [31:0] a);
        return (a >= bsp_pkg::TWB_BUF_LO) && (a <= bsp_pkg::TWB_BUF_HI);
    endfunction

    // a write is issued only when the memory side has drained the last one
    assign hdr_end   = (hdr_idx == 4'(bsp_pkg::HDR_BYTES - 1));
    assign byte_take = byte_v && !wr_pend &&
                       ((state == bsp_pkg::ST_HDR) ||
                        (state == bsp_pkg::ST_BODY) ||
                        (state == bsp_pkg::ST_SKIP));

    // ------------------------------------------------------------
    // header capture
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hdr_idx   <= bsp_pkg::HDR_IDX_W0;
            blk_addr  <= '0;
            blk_cnt   <= '0;
            blk_flags <= '0;
        end else if (state == bsp_pkg::ST_HDR && byte_take) begin
            // RL1 RL17: ordered little-endian fields
            if (hdr_idx <= 4'(bsp_pkg::ADDR_LAST_BYTE)) begin
                blk_addr <= {byte_d, blk_addr[31:8]};
            end else if (hdr_idx <= 4'(bsp_pkg::CNT_LAST_BYTE)) begin
                blk_cnt <= {byte_d, blk_cnt[31:8]};
            end else begin
                blk_flags <= {byte_d, blk_flags[15:8]};
            end
            hdr_idx <= hdr_end ? bsp_pkg::HDR_IDX_W0 : hdr_idx + 4'h1;
        end
    end

    // full flag word as seen on the final header byte
    logic [15:0] flags_now;
    assign flags_now = {byte_d, blk_flags[15:8]};

    // ------------------------------------------------------------
    // block sequencing
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state   <= bsp_pkg::ST_HDR;
            wr_addr <= '0;
            remain  <= '0;
            is_init <= 1'b0;
        end else begin
            case (state)
                bsp_pkg::ST_HDR: begin
                    if (byte_take && hdr_end) begin
                        wr_addr <= blk_addr;
                        remain  <= blk_cnt;
                        is_init <= flags_now[INIT_POS];
                        // RL4: ignored block passes over its body
                        if (flags_now[IGN_POS]) begin
                            state <= (blk_cnt == '0) ? bsp_pkg::ST_HDR : bsp_pkg::ST_SKIP;
                        // RL2: zero-fill has no body
                        end else if (flags_now[ZERO_POS]) begin
                            state <= (blk_cnt == '0) ? bsp_pkg::ST_HDR : bsp_pkg::ST_ZERO;
                        end else if (blk_cnt != '0) begin
                            state <= bsp_pkg::ST_BODY;
                        end else if (flags_now[INIT_POS]) begin
                            state <= bsp_pkg::ST_CALL;
                        end else if (flags_now[LAST_POS]) begin
                            state <= bsp_pkg::ST_DONE;
                        end
                    end
                end
                bsp_pkg::ST_BODY, bsp_pkg::ST_SKIP, bsp_pkg::ST_ZERO: begin
                    if ((state == bsp_pkg::ST_ZERO && !wr_pend) || byte_take) begin
                        wr_addr <= wr_addr + 32'h1;
                        remain  <= remain - 32'h1;
                        if (remain == 32'h1) begin
                            // RL5 RL8: init body is called before loading more
                            if (state != bsp_pkg::ST_SKIP && is_init) begin
                                state <= bsp_pkg::ST_CALL;
                            // RL11 RL12: stop after the last block unless it is ignored
                            end else if (state != bsp_pkg::ST_SKIP && blk_flags[LAST_POS]) begin
                                state <= bsp_pkg::ST_DONE;
                            end else begin
                                state <= bsp_pkg::ST_HDR;
                            end
                        end
                    end
                end
                bsp_pkg::ST_CALL: begin
                    if (!wr_pend) begin
                        state <= bsp_pkg::ST_WAIT_RET;
                    end
                end
                bsp_pkg::ST_WAIT_RET: begin
                    // RL5 RL6: resume only after the return
                    if (ret_i) begin
                        state <= blk_flags[LAST_POS] ? bsp_pkg::ST_DONE : bsp_pkg::ST_HDR;
                    end
                end
                bsp_pkg::ST_DONE: begin
                    state <= bsp_pkg::ST_DONE;
                end
                default: begin
                    state <= bsp_pkg::ST_HDR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // memory write port
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_addr_o <= '0;
            mem_data_o <= '0;
            wr_pend    <= 1'b0;
        end else begin
            if (wr_pend && mem_ready_i) begin
                wr_pend <= 1'b0;
            end
            if (state == bsp_pkg::ST_BODY && byte_take) begin
                mem_addr_o <= wr_addr;
                mem_data_o <= byte_d;
                wr_pend    <= 1'b1;
            // RL2: zeros from the header address
            end else if (state == bsp_pkg::ST_ZERO && !wr_pend) begin
                mem_addr_o <= wr_addr;
                mem_data_o <= bsp_pkg::ZERO_WORD[7:0];
                wr_pend    <= 1'b1;
            end
        end
    end
    assign mem_we_o = wr_pend;

    // ------------------------------------------------------------
    // call, completion and host strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            call_o                <= 1'b0;
            call_addr_o           <= '0;
            stack_pointer_o       <= '0;
            boot_done_o           <= 1'b0;
            jump_addr_o           <= '0;
            host_holdoff_strobe_o <= 1'b0;
            range_err_o           <= 1'b0;
        end else begin
            call_o <= (state == bsp_pkg::ST_CALL) && !wr_pend;
            if (state == bsp_pkg::ST_CALL) begin
                // RL9: stack at scratchpad top before call
                stack_pointer_o <= bsp_pkg::STACK_TOP;
                call_addr_o     <= blk_addr;
            end
            // RL16: hold off the host during init and zero-fill
            host_holdoff_strobe_o <= (state == bsp_pkg::ST_ZERO) ||
                                     (state == bsp_pkg::ST_CALL) ||
                                     (state == bsp_pkg::ST_WAIT_RET);
            // RL13: variant flag picks the jump target
            if (state == bsp_pkg::ST_DONE && !wr_pend) begin
                boot_done_o <= 1'b1;
                jump_addr_o <= blk_flags[PTYPE_POS] ? bsp_pkg::JUMP_VARIANT1
                                                    : bsp_pkg::JUMP_VARIANT0;
            end
            // RL14 RL15: in two-wire mode, a reserved-buffer write outside the last block sets range_err_o
            if (two_wire_boot_mode_i && wr_pend && in_twb_buf(mem_addr_o) &&
                !blk_flags[LAST_POS]) begin
                range_err_o <= 1'b1;
            end
        end
    end

    // RL12: still at the lowest interrupt level on exit
    assign lowest_priority_interrupt_level_o = 1'b1;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_zero_data: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL2
        (mem_we_o && state == bsp_pkg::ST_ZERO) |-> mem_data_o == 8'h00)
        else $error("zero fill wrote nonzero data");
    a_skip_nowrite: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL4
        (state == bsp_pkg::ST_SKIP) |=> !mem_we_o)
        else $error("write issued while skipping");
    a_call_sp: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL9
        call_o |-> stack_pointer_o == bsp_pkg::STACK_TOP)
        else $error("call without stack set");
    a_wait_ret: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL5
        (state == bsp_pkg::ST_WAIT_RET && !ret_i) |=> state == bsp_pkg::ST_WAIT_RET)
        else $error("left call before return");
    a_holdoff_init: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL16
        (state == bsp_pkg::ST_WAIT_RET) |=> host_holdoff_strobe_o)
        else $error("holdoff low during init call");
    a_hdr_nowrite: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL1
        (state == bsp_pkg::ST_HDR && hdr_idx != 4'h0) |-> ##1 !$rose(mem_we_o))
        else $error("write during header");
    a_done_jump: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL13
        $rose(boot_done_o) |-> (jump_addr_o == bsp_pkg::JUMP_VARIANT0 ||
                                jump_addr_o == bsp_pkg::JUMP_VARIANT1))
        else $error("bad jump target");
    a_done_stays: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL11
        boot_done_o |=> boot_done_o && state == bsp_pkg::ST_DONE)
        else $error("parser left done");
    a_done_nowrite: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL12
        boot_done_o |-> !mem_we_o)
        else $error("write after boot done");
    a_call_pulse: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL5
        call_o |=> !call_o)
        else $error("call strobe longer than one cycle");
    a_call_nowrite: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL8
        call_o |-> !mem_we_o)
        else $error("call issued with a write pending");
    a_range_sticky: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // RL14
        range_err_o |=> range_err_o)
        else $error("range error flag cleared");

    // ------------------------------------------------------------
    // scenario coverage
    // ------------------------------------------------------------
    c_init_ret: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        state == bsp_pkg::ST_WAIT_RET && ret_i);
    c_call: cover property (@(posedge mclk_i) disable iff (!arst_n_i) call_o);
    c_zero: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        state == bsp_pkg::ST_ZERO);
    c_skip: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
        state == bsp_pkg::ST_SKIP);
    c_done: cover property (@(posedge mclk_i) disable iff (!arst_n_i) $rose(boot_done_o));
endmodule

/* verif/bsp_src.sv */
`timescale 1ns/1ps
module bsp_src (
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    input  wire logic       src_ready_i,
    input  wire logic       holdoff_i,
    input  wire logic       stall_i,
    output logic [7:0]      data_o,
    output logic            valid_o
);
    logic [7:0] q[$];

    // stream order
    // the bench pushes whole blocks: header then body, init blocks first
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask

    // --------------------------------------------------------
    // byte offer
    // --------------------------------------------------------
    // pause on holdoff
    // a released data line toggles between the last byte and its complement
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            valid_o <= 1'b0;
            data_o  <= 8'h5A;
            q.delete();
        end else begin
            if (valid_o && src_ready_i) begin
                void'(q.pop_front());
            end
            if (valid_o && !src_ready_i) begin
                valid_o <= 1'b1;
            end else if (q.size() != 0 && !holdoff_i && !stall_i) begin
                valid_o <= 1'b1;
                data_o  <= q[0];
            end else begin
                valid_o <= 1'b0;
                data_o  <= ~data_o;
            end
        end
    end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam logic [15:0] F_ZERO = 16'h0001 << bsp_pkg::FLAG_ZERO_POS;
    localparam logic [15:0] F_PTYP = 16'h0001 << bsp_pkg::FLAG_PTYPE_POS;
    localparam logic [15:0] F_INIT = 16'h0001 << bsp_pkg::FLAG_INIT_POS;
    localparam logic [15:0] F_IGN  = 16'h0001 << bsp_pkg::FLAG_IGN_POS;
    localparam logic [15:0] F_LAST = 16'h0001 << bsp_pkg::FLAG_LAST_POS;
    logic        mclk_i, arst_n_i, src_valid_i, src_ready_o, two_wire_i, mem_we_o;
    logic        mem_ready_i, call_o, boot_done_o, lpil_o, holdoff_o, range_err_o;
    logic        ret_i = 1'b0;
    logic        stall;
    logic [7:0]  src_data_i, mem_data_o;
    logic [31:0] mem_addr_o, call_addr_o, sp_o, jump_addr_o;
    logic [15:0] rseed = 16'h0009;
    logic [15:0] dseed;
    logic [40:0] expq[$];
    logic [63:0] callq[$];
    int          miscompares, num_checks, exp_total, wr_count;
    bit          waiting;

    bsp_parser bsp_parser_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .src_data_i(src_data_i),
        .src_valid_i(src_valid_i), .src_ready_o(src_ready_o),
        .two_wire_boot_mode_i(two_wire_i), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
        .mem_we_o(mem_we_o), .mem_ready_i(mem_ready_i), .call_o(call_o),
        .call_addr_o(call_addr_o), .stack_pointer_o(sp_o), .ret_i(ret_i),
        .boot_done_o(boot_done_o), .jump_addr_o(jump_addr_o),
        .lowest_priority_interrupt_level_o(lpil_o), .host_holdoff_strobe_o(holdoff_o),
        .range_err_o(range_err_o));
    bsp_src bsp_src_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .src_ready_i(src_ready_o),
        .holdoff_i(holdoff_o), .stall_i(stall), .data_o(src_data_i), .valid_o(src_valid_i));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
        cmp32({24'h000000, g}, {24'h000000, e});
    endtask
    task automatic cmp1(input logic g, input logic e);
        cmp32({31'h00000000, g}, {31'h00000000, e});
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // --------------------------------------------------------
    // stimulus helpers
    // --------------------------------------------------------
    // little-endian header
    task automatic blk(input logic [31:0] a, input logic [31:0] n, input logic [15:0] f);
        int k;
        for (k = 0; k < 4; k++) bsp_src_i.push(a[8*k +: 8]);
        for (k = 0; k < 4; k++) bsp_src_i.push(n[8*k +: 8]);
        for (k = 0; k < 2; k++) bsp_src_i.push(f[8*k +: 8]);
        for (k = 0; k < n; k++) begin
            dseed = lfsr(dseed);
            if (f & F_ZERO) begin
                // the strobe falls a cycle after the last zero write issues
                expq.push_back({(32'(k) != n - 32'h1), a + 32'(k), 8'h00});
            end else begin
                bsp_src_i.push(dseed[7:0]);
                if (!(f & F_IGN)) expq.push_back({1'b0, a + 32'(k), dseed[7:0]});
            end
            if (!(f & (F_IGN | F_ZERO)) || (f & F_ZERO)) exp_total++;
        end
        if (f & F_INIT) callq.push_back({32'(exp_total), a});
    endtask
    task automatic do_reset();
        arst_n_i <= 1'b0;
        expq.delete();
        callq.delete();
        exp_total = 0;
        wr_count  = 0;
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
    endtask
    task automatic finish_run(input logic [31:0] jmp, input logic err);
        int i;
        for (i = 0; i < 4000 && boot_done_o !== 1'b1; i++) @(posedge mclk_i);
        if (i >= 4000) begin
            miscompares++;
            results();
        end
        cmp32(jump_addr_o, jmp);
        cmp1(range_err_o, err);
        cmp1(lpil_o, 1'b1);
        cmp32(32'(expq.size()), 32'h00000000);
        cmp32(32'(callq.size()), 32'h00000000);
    endtask

    // --------------------------------------------------------
    // memory and init-code side
    // --------------------------------------------------------
    always @(posedge mclk_i) begin
        rseed       <= lfsr(rseed);
        mem_ready_i <= rseed[0] | rseed[1];
        stall       <= rseed[2] & rseed[3];
    end
    always @(posedge mclk_i) begin
        logic [40:0] e;
        if (arst_n_i && mem_we_o === 1'b1 && mem_ready_i === 1'b1) begin
            e = (expq.size() != 0) ? expq.pop_front() : {1'b0, ~mem_addr_o, ~mem_data_o};
            cmp1(waiting, 1'b0);
            cmp32(mem_addr_o, e[39:8]);
            cmp8(mem_data_o, e[7:0]);
            if (e[40]) cmp1(holdoff_o, 1'b1);
            wr_count++;
        end
    end
    always @(posedge mclk_i) begin
        logic [63:0] c;
        if (arst_n_i && call_o === 1'b1) begin
            c = (callq.size() != 0) ? callq.pop_front() : {32'hFFFFFFFF, ~call_addr_o};
            cmp32(call_addr_o, c[31:0]);
            cmp32(sp_o, bsp_pkg::STACK_TOP);
            cmp32(32'(wr_count), c[63:32]);
            waiting = 1'b1;
            repeat (6) @(posedge mclk_i);
            cmp1(holdoff_o, 1'b1);
            ret_i <= 1'b1;
            @(posedge mclk_i);
            ret_i   <= 1'b0;
            waiting = 1'b0;
            cmp32(sp_o, bsp_pkg::STACK_TOP);
        end
    end

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        arst_n_i = 1'b0;
        two_wire_i = 1'b1;
        dseed = 16'h0009;
        miscompares = 0;
        num_checks = 0;
        do_reset();
        cmp1(src_ready_o, 1'b1);
        cmp1(mem_we_o, 1'b0);
        cmp1(boot_done_o, 1'b0);
        cmp1(holdoff_o, 1'b0);
        $display("test reset done");
        // two init blocks back to back, then zero, ignore, reserved hit
        blk(32'hFFA00100, 32'h00000006, F_INIT);
        blk(32'hFFA00200, 32'h00000003, F_INIT);
        blk(32'hFF800010, 32'h00000005, F_ZERO);
        blk(32'hFF800100, 32'h00000004, F_IGN);
        blk(32'hFF903FFC, 32'h00000004, 16'h0000);
        blk(32'hFF800200, 32'h00000003, F_LAST | F_PTYP);
        finish_run(bsp_pkg::JUMP_VARIANT1, 1'b1);
        $display("test boot_a done");
        do_reset();
        // just below the reserved range, and the last block inside it
        blk(32'hFF903EFC, 32'h00000004, 16'h0000);
        blk(32'hFF800300, 32'h00000001, F_ZERO);
        blk(bsp_pkg::TWB_BUF_LO, 32'h00000002, F_LAST);
        finish_run(bsp_pkg::JUMP_VARIANT0, 1'b0);
        $display("test boot_b done");
        do_reset();
        two_wire_i <= 1'b0;
        // zero-count init block, then reserved range without two-wire mode
        blk(32'hFFA00300, 32'h00000000, F_INIT);
        blk(32'hFF903F10, 32'h00000002, 16'h0000);
        blk(32'hFF800400, 32'h00000001, F_LAST);
        finish_run(bsp_pkg::JUMP_VARIANT0, 1'b0);
        $display("test boot_c done");
        results();
    end
endmodule
